// File: rtl/ips_pkg.sv
package ips_pkg;
  localparam int unsigned NUM_SRC = 18;
  localparam int unsigned NUM_LVL = 4;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PRIO_HIGH_BASE = 8'hB7;
  localparam logic [7:0] IDX_PRIO_LOW_BASE = 8'hB8;
  localparam logic [7:0] IDX_PRIO_LOW_EXT = 8'hEF;
  localparam logic [7:0] IDX_PRIO_HIGH_EXT = 8'hF7;
  localparam logic [7:0] IDX_PRIO_LOW_EXT2 = 8'hFE;
  localparam logic [7:0] IDX_PRIO_HIGH_EXT2 = 8'hFF;
  localparam logic [7:0] IDX_STATUS = 8'hC0;
  localparam logic [7:0] IDX_VECTOR = 8'hC1;
  // writable masks and reset values
  localparam logic [7:0] MASK_BASE = 8'h7F;
  localparam logic [7:0] MASK_EXT = 8'hFF;
  localparam logic [7:0] MASK_EXT2 = 8'h07;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  // base bit positions
  localparam int unsigned BIT_EXTINT0 = 0;
  localparam int unsigned BIT_TIMER0 = 1;
  localparam int unsigned BIT_EXTINT1 = 2;
  localparam int unsigned BIT_TIMER1 = 3;
  localparam int unsigned BIT_SERIAL0 = 4;
  localparam int unsigned BIT_BROWNOUT = 5;
  localparam int unsigned BIT_ADC = 6;
  // extended bit positions
  localparam int unsigned BIT_TWO_WIRE = 0;
  localparam int unsigned BIT_PIN_IRQ = 1;
  localparam int unsigned BIT_CAPTURE = 2;
  localparam int unsigned BIT_PULSE_WIDTH = 3;
  localparam int unsigned BIT_WATCHDOG = 4;
  localparam int unsigned BIT_FAULT_BRAKE = 5;
  localparam int unsigned BIT_SERIAL_PERIPH = 6;
  localparam int unsigned BIT_TIMER2 = 7;
  // second extended bit positions
  localparam int unsigned BIT_SERIAL1 = 0;
  localparam int unsigned BIT_TIMER3 = 1;
  localparam int unsigned BIT_WAKE_TIMER = 2;
  // call timing
  localparam logic [2:0] CALL_CYCLES = 3'h4;
  // vectors in natural rank order, index 0 best
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h0043, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
    16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h0073, 16'h004B,
    16'h002B, 16'h0063, 16'h006B, 16'h007B, 16'h0083, 16'h008B};
  typedef enum logic [1:0] {IPS_IDLE, IPS_CALL} ips_state_e;
endpackage : ips_pkg

// File: rtl/ips_level.sv
`timescale 1ns/1ps
`default_nettype none
module ips_level (
  // priority bits and request flag
  input wire logic lo_bit,
  input wire logic hi_bit,
  input wire logic req,
  // decoded level, one-hot, zero when idle
  output logic [3:0] lvl_onehot
);
  always_comb
  begin
    lvl_onehot = 4'h0;
    if (req)
    begin
      lvl_onehot[{hi_bit, lo_bit}] = 1'b1;
    end
  end
endmodule : ips_level
`default_nettype wire

// File: rtl/ips_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module ips_arbiter (
  // requests at one level, rank order
  input wire logic [17:0] req,
  // winner
  output logic found,
  output logic [4:0] idx
);
  always_comb
  begin
    found = 1'b0;
    idx = 5'h00;
    for (int i = 17; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx = 5'(i);
      end
    end
  end
endmodule : ips_arbiter
`default_nettype wire

// File: rtl/ips_ctrl.sv
// How it works
// - level from low bit plus companion high bit
// - high,low pair gives levels zero to three
// - base low: ADC6 down to extint0 bit0
// - base high mirrors base low layout
// - ext low: timer2 bit7 down to two-wire
// - ext high mirrors ext low layout
// - ext2 low: wake2, timer3 1, serial1 0
// - ext2 high mirrors ext2 low layout
// - priority registers reset to zero
// - sample and resolve requests every cycle
// - no call if equal/higher level serviced
// - call only on instruction last cycle
// - no call on priority/enable write or return
// - blocked requests are not remembered
// - call pushes pc only, loads vector
// - return clears top service level; plain return keeps it
// - forced call lasts four clocks
// - worst response within sixteen clocks
// - preempt only by strictly higher level
// - ties go to best natural rank
`timescale 1ns/1ps
`default_nettype none
module ips_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // request flags, natural rank order, bit 0 best
  input wire logic [17:0] irq_flag,
  // instruction sequencer
  input wire logic insn_last_cycle,
  input wire logic insn_writes_ie_ip,
  input wire logic insn_is_return_from_interrupt,
  input wire logic insn_is_ret,
  // forced call to sequencer
  output logic call_busy,
  output logic call_start,
  output logic push_pc_only,
  output logic [15:0] call_vector,
  output logic call_done,
  output logic [3:0] in_service,
  output logic pop_pc
);
  typedef struct packed {
    logic [7:0] lo_base;
    logic [7:0] hi_base;
    logic [7:0] lo_ext;
    logic [7:0] hi_ext;
    logic [7:0] lo_ext2;
    logic [7:0] hi_ext2;
    logic [3:0] serv;
    ips_pkg::ips_state_e st;
    logic [2:0] cnt;
    logic busy;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic call_start;
    logic push_pc_only;
    logic [15:0] call_vector;
    logic call_done;
    logic pop_pc;
  } ips_state_s;

  ips_state_s cur;
  ips_state_s next_cur;

  logic [17:0] lo_vec;
  logic [17:0] hi_vec;
  logic [3:0] lvl_oh [18];
  logic [17:0] at_lvl [4];
  logic [3:0] lvl_found;
  logic [4:0] lvl_idx [4];
  logic [1:0] top_serv;
  logic serv_any;
  logic [1:0] win_lvl;
  logic win_any;
  logic [4:0] win_idx;
  logic may_call;
  logic [11:0] word_addr;
  logic addr_ok;
  logic prio_wr;

  // map register bits onto the natural rank order
  always_comb
  begin
    lo_vec = {cur.lo_ext2[ips_pkg::BIT_WAKE_TIMER], cur.lo_ext2[ips_pkg::BIT_TIMER3],
      cur.lo_ext2[ips_pkg::BIT_SERIAL1], cur.lo_ext[ips_pkg::BIT_PULSE_WIDTH],
      cur.lo_ext[ips_pkg::BIT_CAPTURE], cur.lo_ext[ips_pkg::BIT_TIMER2],
      cur.lo_ext[ips_pkg::BIT_SERIAL_PERIPH], cur.lo_ext[ips_pkg::BIT_FAULT_BRAKE],
      cur.lo_base[ips_pkg::BIT_SERIAL0], cur.lo_base[ips_pkg::BIT_TIMER1],
      cur.lo_ext[ips_pkg::BIT_PIN_IRQ], cur.lo_base[ips_pkg::BIT_EXTINT1],
      cur.lo_base[ips_pkg::BIT_ADC], cur.lo_ext[ips_pkg::BIT_TWO_WIRE],
      cur.lo_base[ips_pkg::BIT_TIMER0], cur.lo_ext[ips_pkg::BIT_WATCHDOG],
      cur.lo_base[ips_pkg::BIT_BROWNOUT], cur.lo_base[ips_pkg::BIT_EXTINT0]};
    hi_vec = {cur.hi_ext2[ips_pkg::BIT_WAKE_TIMER], cur.hi_ext2[ips_pkg::BIT_TIMER3],
      cur.hi_ext2[ips_pkg::BIT_SERIAL1], cur.hi_ext[ips_pkg::BIT_PULSE_WIDTH],
      cur.hi_ext[ips_pkg::BIT_CAPTURE], cur.hi_ext[ips_pkg::BIT_TIMER2],
      cur.hi_ext[ips_pkg::BIT_SERIAL_PERIPH], cur.hi_ext[ips_pkg::BIT_FAULT_BRAKE],
      cur.hi_base[ips_pkg::BIT_SERIAL0], cur.hi_base[ips_pkg::BIT_TIMER1],
      cur.hi_ext[ips_pkg::BIT_PIN_IRQ], cur.hi_base[ips_pkg::BIT_EXTINT1],
      cur.hi_base[ips_pkg::BIT_ADC], cur.hi_ext[ips_pkg::BIT_TWO_WIRE],
      cur.hi_base[ips_pkg::BIT_TIMER0], cur.hi_ext[ips_pkg::BIT_WATCHDOG],
      cur.hi_base[ips_pkg::BIT_BROWNOUT], cur.hi_base[ips_pkg::BIT_EXTINT0]};
  end

  // flags are read live each cycle, nothing latched
  for (genvar s = 0; s < 18; s++)
  begin : g_src
    ips_level u_level (
      .lo_bit(lo_vec[s]),
      .hi_bit(hi_vec[s]),
      .req(irq_flag[s]),
      .lvl_onehot(lvl_oh[s])
    );
  end

  for (genvar l = 0; l < 4; l++)
  begin : g_lvl
    for (genvar s = 0; s < 18; s++)
    begin : g_bit
      assign at_lvl[l][s] = lvl_oh[s][l];
    end
    ips_arbiter u_arb (
      .req(at_lvl[l]),
      .found(lvl_found[l]),
      .idx(lvl_idx[l])
    );
  end

  always_comb
  begin
    win_any = 1'b0;
    win_lvl = 2'h0;
    win_idx = 5'h00;
    for (int l = 0; l < 4; l++)
    begin
      if (lvl_found[l])
      begin
        win_any = 1'b1;
        win_lvl = 2'(l);
        win_idx = lvl_idx[l];
      end
    end
    serv_any = |cur.serv;
    top_serv = 2'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (cur.serv[l])
      begin
        top_serv = 2'(l);
      end
    end
  end

  // a priority write in the deciding cycle would race the level compare
  always_comb
  begin
    prio_wr = 1'b0;
    if (psel && penable && pwrite && !cur.pready && addr_ok)
    begin
      case (word_addr[7:0])
        ips_pkg::IDX_PRIO_LOW_BASE, ips_pkg::IDX_PRIO_HIGH_BASE,
          ips_pkg::IDX_PRIO_LOW_EXT, ips_pkg::IDX_PRIO_HIGH_EXT,
          ips_pkg::IDX_PRIO_LOW_EXT2, ips_pkg::IDX_PRIO_HIGH_EXT2:
        begin
          prio_wr = 1'b1;
        end
        default:
        begin
          prio_wr = 1'b0;
        end
      endcase
    end
  end

  // strictly higher than anything in service
  assign may_call = win_any && (!serv_any || (win_lvl > top_serv))
    && insn_last_cycle
    && !insn_writes_ie_ip && !insn_is_return_from_interrupt && !insn_is_ret && !prio_wr
    && (cur.st == ips_pkg::IPS_IDLE);

  assign word_addr = paddr >> 2;
  assign addr_ok = (word_addr[11:8] == 4'h0);

  always_comb
  begin
    next_cur = cur;
    next_cur.call_start = 1'b0;
    next_cur.call_done = 1'b0;
    next_cur.pop_pc = 1'b0;
    next_cur.pready = 1'b0;
    next_cur.pslverr = 1'b0;
    // apb: one wait state, answer registered
    if (psel && penable && !cur.pready)
    begin
      next_cur.pready = 1'b1;
      next_cur.prdata = 32'h0000_0000;
      // writes need clean upper bits so aliases cannot land
      case (word_addr[7:0])
        ips_pkg::IDX_PRIO_LOW_BASE:
        begin
          if (pwrite && addr_ok) next_cur.lo_base = pwdata[7:0] & ips_pkg::MASK_BASE;
          next_cur.prdata[7:0] = cur.lo_base;
        end
        ips_pkg::IDX_PRIO_HIGH_BASE:
        begin
          if (pwrite && addr_ok) next_cur.hi_base = pwdata[7:0] & ips_pkg::MASK_BASE;
          next_cur.prdata[7:0] = cur.hi_base;
        end
        ips_pkg::IDX_PRIO_LOW_EXT:
        begin
          if (pwrite && addr_ok) next_cur.lo_ext = pwdata[7:0] & ips_pkg::MASK_EXT;
          next_cur.prdata[7:0] = cur.lo_ext;
        end
        ips_pkg::IDX_PRIO_HIGH_EXT:
        begin
          if (pwrite && addr_ok) next_cur.hi_ext = pwdata[7:0] & ips_pkg::MASK_EXT;
          next_cur.prdata[7:0] = cur.hi_ext;
        end
        ips_pkg::IDX_PRIO_LOW_EXT2:
        begin
          if (pwrite && addr_ok) next_cur.lo_ext2 = pwdata[7:0] & ips_pkg::MASK_EXT2;
          next_cur.prdata[7:0] = cur.lo_ext2;
        end
        ips_pkg::IDX_PRIO_HIGH_EXT2:
        begin
          if (pwrite && addr_ok) next_cur.hi_ext2 = pwdata[7:0] & ips_pkg::MASK_EXT2;
          next_cur.prdata[7:0] = cur.hi_ext2;
        end
        ips_pkg::IDX_STATUS:
        begin
          next_cur.prdata[4:0] = {cur.busy, cur.serv};
        end
        ips_pkg::IDX_VECTOR:
        begin
          next_cur.prdata[15:0] = cur.call_vector;
        end
        default:
        begin
          next_cur.pslverr = 1'b1;
        end
      endcase
      if (!addr_ok)
      begin
        next_cur.pslverr = 1'b1;
      end
    end
    // return from interrupt drops the top in-service level
    // nothing in service still pops the stack
    if (insn_is_return_from_interrupt && insn_last_cycle)
    begin
      if (serv_any)
      begin
        next_cur.serv[top_serv] = 1'b0;
      end
      next_cur.pop_pc = 1'b1;
    end
    else if (insn_is_ret && insn_last_cycle)
    begin
      next_cur.pop_pc = 1'b1;
    end
    case (cur.st)
      ips_pkg::IPS_IDLE:
      begin
        if (may_call)
        begin
          next_cur.st = ips_pkg::IPS_CALL;
          next_cur.busy = 1'b1;
          next_cur.cnt = 3'h1;
          next_cur.call_start = 1'b1;
          next_cur.push_pc_only = 1'b1;
          next_cur.call_vector = ips_pkg::VEC_TABLE[win_idx];
          next_cur.serv[win_lvl] = 1'b1;
        end
      end
      ips_pkg::IPS_CALL:
      begin
        // fixed length keeps worst case at sixteen clocks
        if (cur.cnt == ips_pkg::CALL_CYCLES)
        begin
          next_cur.st = ips_pkg::IPS_IDLE;
          next_cur.busy = 1'b0;
          next_cur.push_pc_only = 1'b0;
          next_cur.call_done = 1'b1;
        end
        else
        begin
          next_cur.cnt = cur.cnt + 3'h1;
        end
      end
      default:
      begin
        next_cur.st = ips_pkg::IPS_IDLE;
        next_cur.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cur <= '0;
      cur.lo_base <= ips_pkg::PRIO_RESET;
      cur.hi_base <= ips_pkg::PRIO_RESET;
      cur.lo_ext <= ips_pkg::PRIO_RESET;
      cur.hi_ext <= ips_pkg::PRIO_RESET;
      cur.lo_ext2 <= ips_pkg::PRIO_RESET;
      cur.hi_ext2 <= ips_pkg::PRIO_RESET;
      cur.st <= ips_pkg::IPS_IDLE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign pready = cur.pready;
  assign prdata = cur.prdata;
  assign pslverr = cur.pslverr;
  assign call_busy = cur.busy;
  assign call_start = cur.call_start;
  assign push_pc_only = cur.push_pc_only;
  assign call_vector = cur.call_vector;
  assign call_done = cur.call_done;
  assign in_service = cur.serv;
  assign pop_pc = cur.pop_pc;
endmodule : ips_ctrl
`default_nettype wire

// File: test/ips_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ips_ctrl_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // sequencer side
  input wire logic [17:0] irq_flag,
  input wire logic insn_last_cycle,
  input wire logic insn_writes_ie_ip,
  input wire logic insn_is_return_from_interrupt,
  input wire logic insn_is_ret,
  input wire logic call_busy,
  input wire logic call_start,
  input wire logic push_pc_only,
  input wire logic [15:0] call_vector,
  input wire logic call_done,
  input wire logic [3:0] in_service,
  input wire logic pop_pc
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic can_call;
  // a return only retires the top level
  function automatic logic [3:0] clr_top(input logic [3:0] s);
    clr_top = s[3] ? {1'h0, s[2:0]} : s[2] ? {2'h0, s[1:0]} : s[1] ? {3'h0, s[0]} : 4'h0;
  endfunction : clr_top
  always_ff @(posedge core_clk)
    can_call <= insn_last_cycle && !insn_writes_ie_ip && !insn_is_return_from_interrupt && !insn_is_ret
      && (irq_flag != 18'h0);
  busy_len_a: assert property ($rose(call_busy) |-> call_busy[*4] ##1 !call_busy)
    else $error("forced call not four cycles");
  call_done_a: assert property ($fell(call_busy) |-> call_done)
    else $error("no done after call");
  start_cause_a: assert property (call_start |-> can_call)
    else $error("call without a legal cause");
  serv_level_a: assert property (call_start |->
    $onehot(in_service ^ $past(in_service)) && ((in_service ^ $past(in_service)) > $past(in_service)))
    else $error("call not above serviced level");
  push_only_a: assert property (call_busy |-> push_pc_only && (call_start || $stable(call_vector)))
    else $error("call push or vector wrong");
  ret_pop_a: assert property ((insn_is_return_from_interrupt || insn_is_ret) && insn_last_cycle |=> pop_pc)
    else $error("return without pop");
  return_from_interrupt_clear_a: assert property (insn_is_return_from_interrupt && insn_last_cycle |=>
    in_service == clr_top($past(in_service)))
    else $error("return did not clear top level");
  ret_keep_a: assert property (insn_is_ret && !insn_is_return_from_interrupt && insn_last_cycle |=> $stable(in_service))
    else $error("plain return changed service");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  err_pulse_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property (call_start);
  cover property (pop_pc && in_service == 4'h0);
  cover property (pslverr);
endmodule : ips_ctrl_properties
bind ips_ctrl ips_ctrl_properties u_props (.core_clk(core_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .irq_flag(irq_flag),
  .insn_last_cycle(insn_last_cycle), .insn_writes_ie_ip(insn_writes_ie_ip),
  .insn_is_return_from_interrupt(insn_is_return_from_interrupt), .insn_is_ret(insn_is_ret), .call_busy(call_busy),
  .call_start(call_start), .push_pc_only(push_pc_only), .call_vector(call_vector),
  .call_done(call_done), .in_service(in_service), .pop_pc(pop_pc));
`default_nettype wire

// File: test/ips_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module ips_seq_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // forced call in progress
  input wire logic call_busy,
  // instruction boundary
  output logic insn_last_cycle
);
  // two-cycle instructions; stalls while running the forced call
  logic phase;
  always_ff @(posedge core_clk)
    phase <= (!nrst || call_busy) ? 1'h0 : ~phase;
  assign insn_last_cycle = phase & ~call_busy;
endmodule : ips_seq_model
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] a, w, e;} ips_reg_s;
  typedef struct {logic [7:0] ha, la, hb, lb; logic [17:0] f; int w; logic [3:0] s;} ips_row_s;
  ips_reg_s regs [6] = '{'{8'hB7, 8'hFF, 8'h7F}, '{8'hB8, 8'hFF, 8'h7F},
    '{8'hEF, 8'hA5, 8'hA5}, '{8'hF7, 8'h5A, 8'h5A}, '{8'hFE, 8'hFF, 8'h07},
    '{8'hFF, 8'hFF, 8'h07}};
  ips_row_s rows [6] = '{'{8'hB7, 8'hB8, 8'h00, 8'h00, 18'h3FFFF, 0, 4'h1},
    '{8'hB7, 8'hB8, 8'h00, 8'h40, 18'h00021, 5, 4'h2},
    '{8'hB7, 8'hB8, 8'h10, 8'h40, 18'h00220, 9, 4'h4},
    '{8'hF7, 8'hEF, 8'h10, 8'h10, 18'h00204, 2, 4'h8},
    '{8'hFF, 8'hFE, 8'h02, 8'h00, 18'h10001, 16, 4'h4},
    '{8'hFF, 8'hFE, 8'h04, 8'h04, 18'h30000, 17, 4'h8}};
  logic core_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic wr_ie = 1'h0, is_return_from_interrupt = 1'h0, is_ret = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [17:0] irq_flag = 18'h0;
  logic pready, pslverr, last_cyc, busy, start, push_only, done, pop, er;
  logic [31:0] prdata, rd;
  logic [15:0] vec;
  logic [3:0] serv;
  int error_cnt = 0, n_checks = 0, cyc = 0, calls = 0, n, c;
  ips_ctrl dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq_flag(irq_flag), .insn_last_cycle(last_cyc),
    .insn_writes_ie_ip(wr_ie), .insn_is_return_from_interrupt(is_return_from_interrupt), .insn_is_ret(is_ret),
    .call_busy(busy), .call_start(start), .push_pc_only(push_only), .call_vector(vec),
    .call_done(done), .in_service(serv), .pop_pc(pop));
  ips_seq_model u_seq (.core_clk(core_clk), .nrst(nrst), .call_busy(busy),
    .insn_last_cycle(last_cyc));
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    calls <= calls + int'(start === 1'h1);
    if (cyc == 5000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // held until pready is seen at an edge, then released
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'h1;
    n = 0;
    do @(posedge core_clk); while (pready !== 1'h1 && ++n < 50);
    rd = prdata;
    er = pslverr;
    chk(32'(n < 50), 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  task automatic wait_done();
    n = 0;
    do @(posedge core_clk); while (done !== 1'h1 && ++n < 40);
    chk(32'(done === 1'h1), 32'h1);
  endtask : wait_done
  task automatic ret_op(input logic full);
    is_return_from_interrupt <= full;
    is_ret <= ~full;
    n = 0;
    do @(posedge core_clk); while (pop !== 1'h1 && ++n < 20);
    chk(32'(pop === 1'h1), 32'h1);
    is_return_from_interrupt <= 1'h0;
    is_ret <= 1'h0;
    @(posedge core_clk);
  endtask : ret_op
  initial
  begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    foreach (regs[i])
    begin
      apb(1'h0, regs[i].a, 8'h00);
      chk(rd, 32'h0);
      apb(1'h1, regs[i].a, regs[i].w);
      apb(1'h0, regs[i].a, 8'h00);
      chk(rd, {24'h0, regs[i].e});
      apb(1'h1, regs[i].a, 8'h00);
    end
    apb(1'h1, 8'hC4, 8'hFF);
    chk(32'(er), 32'h1);
    $display("register test done");
    foreach (rows[i])
    begin
      apb(1'h1, rows[i].ha, rows[i].hb);
      apb(1'h1, rows[i].la, rows[i].lb);
      irq_flag <= rows[i].f;
      wait_done();
      irq_flag <= 18'h0;
      chk(32'(n >= 5 && n <= 16), 32'h1);
      chk(vec, ips_pkg::VEC_TABLE[rows[i].w]);
      chk(serv, rows[i].s);
      apb(1'h0, ips_pkg::IDX_VECTOR, 8'h00);
      chk(rd, {16'h0, ips_pkg::VEC_TABLE[rows[i].w]});
      apb(1'h0, ips_pkg::IDX_STATUS, 8'h00);
      chk(rd, {28'h0, rows[i].s});
      ret_op(1'h1);
      chk(serv, 4'h0);
    end
    $display("priority table done");
    irq_flag <= 18'h00004;
    wait_done();
    c = calls;
    irq_flag <= 18'h00221;
    repeat (12) @(posedge core_clk);
    chk(calls - c, 0);
    ret_op(1'h0);
    chk(serv, 4'h8);
    ret_op(1'h1);
    wait_done();
    chk(vec, ips_pkg::VEC_TABLE[9]);
    irq_flag <= 18'h00004;
    wait_done();
    irq_flag <= 18'h0;
    chk(serv, 4'hC);
    ret_op(1'h1);
    chk(serv, 4'h4);
    ret_op(1'h1);
    $display("nesting test done");
    c = calls;
    wr_ie <= 1'h1;
    irq_flag <= 18'h00001;
    repeat (10) @(posedge core_clk);
    irq_flag <= 18'h0;
    wr_ie <= 1'h0;
    repeat (10) @(posedge core_clk);
    chk(calls - c, 0);
    ret_op(1'h1);
    chk(serv, 4'h0);
    $display("blocking test done");
    irq_flag <= 18'h00001;
    wait_done();
    irq_flag <= 18'h0;
    apb(1'h1, 8'hEF, 8'h5A);
    nrst <= 1'h0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    chk(serv, 4'h0);
    apb(1'h0, 8'hEF, 8'h00);
    chk(rd, 32'h0);
    $display("reset test done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
